// ==== usu_shift_unit.sv ====
// universal serial shift unit with axi4-lite register access
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - serial clock and data rate at most half the system clock
// - as two-wire slave hold clock line low until ready for more
// - external clock pin increments counter on both edges
// - counter preset to maximum with external clock overflows on next edge
// - shift clock shifts left taking serial input; cpu write wins
// - input pins feed register and counter even with outputs disabled
// - output pin driven from data msb through an output latch, except wire mode 00 which drives the port bit
// - latch open in first half with external clock, always with internal
// - new msb reaches pin at once while latch open
// - data reaches pin only when its direction bit is output
// - on transfer completion data copied into receive copy
// - start flag on start condition, or any clock edge outside two-wire
// - start flag cleared by writing one, which releases clock hold
// - start interrupt wakes processor from every sleep mode
// - overflow flag on wrap 15 to 0, write one clears and releases hold
// - overflow interrupt wakes processor from idle only
// - stop flag set on stop condition, write one clears, no interrupt
// - collision bit reads one when msb differs from data pin
// - low status bits are the counter, incremented by selected clock
// - external source with soft clock selected: toggle strobe clocks
// - enables gate flags; pending flag interrupts at once when enabled
// - wire mode 11 also holds clock low after overflow until cleared
// - clock source zero: soft clock strobe clocks register and counter
module usu_shift_unit (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        serial_in_pin,
   input  wire logic        serial_clock_pin,
   input  wire logic        timer_match,
   input  wire logic        global_irq_enable,
   output logic             data_pin_out,
   output logic             data_pin_oe,
   output logic             clock_pin_out,
   output logic             clock_pin_oe,
   output logic             start_irq,
   output logic             overflow_irq,
   output logic             start_wake
);
   // ==========================================================
   // address decode
   function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
      hit = (a[7:2] == idx);
   endfunction

   logic        aw_got_reg;
   logic        w_got_reg;
   logic [7:0]  aw_addr_reg;
   logic [7:0]  wb_reg;
   logic        wl_reg;
   logic        wr_do;
   logic        ar_hs;
   logic [7:0]  control_reg;
   logic [7:0]  shift_data_reg;
   logic [7:0]  receive_copy_reg;
   logic [3:0]  clock_count;
   logic [3:0]  pin_ctl_reg;
   logic        start_flag;
   logic        overflow_flag;
   logic        stop_flag;
   logic        soft_sel_reg;
   logic        start_hold_reg;
   logic        latch_reg;
   logic        din_s1, din_s2, din_s3;
   logic        clk_s1, clk_s2, clk_s3;

   assign wr_do = aw_got_reg & w_got_reg & ~bvalid;
   assign ar_hs = arvalid & arready;

   // ==========================================================
   // axi4-lite write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg  <= 1'b0;
         w_got_reg   <= 1'b0;
         awready     <= 1'b1;
         wready      <= 1'b1;
         bvalid      <= 1'b0;
         bresp       <= usu_pkg::RESP_OKAY;
         aw_addr_reg <= 8'h00;
         wb_reg      <= 8'h00;
         wl_reg      <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_got_reg  <= 1'b1;
            awready     <= 1'b0;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_reg <= 1'b1;
            wready    <= 1'b0;
            wb_reg    <= wdata[7:0];
            wl_reg    <= wstrb[0];
         end
         if (wr_do) begin
            bvalid <= 1'b1;
            bresp  <= (hit(aw_addr_reg, usu_pkg::IDX_CONTROL) ||
                       hit(aw_addr_reg, usu_pkg::IDX_STATUS) ||
                       hit(aw_addr_reg, usu_pkg::IDX_SHIFT) ||
                       hit(aw_addr_reg, usu_pkg::IDX_RECEIVE) ||
                       hit(aw_addr_reg, usu_pkg::IDX_PIN_CTL)) ?
                      usu_pkg::RESP_OKAY : usu_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid     <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awready    <= 1'b1;
            wready     <= 1'b1;
         end
      end
   end

   // write pulses, only byte lane 0 carries register data
   logic ctl_wr, st_wr, sd_wr, pin_wr;
   logic [7:0] wb;
   assign wb     = wb_reg;
   assign ctl_wr = wr_do & wl_reg & hit(aw_addr_reg, usu_pkg::IDX_CONTROL);
   assign st_wr  = wr_do & wl_reg & hit(aw_addr_reg, usu_pkg::IDX_STATUS);
   assign sd_wr  = wr_do & wl_reg & hit(aw_addr_reg, usu_pkg::IDX_SHIFT);
   assign pin_wr = wr_do & wl_reg & hit(aw_addr_reg, usu_pkg::IDX_PIN_CTL);

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {din_s1, din_s2, din_s3} <= 3'b111;
         {clk_s1, clk_s2, clk_s3} <= 3'b000;
      end else if (ce) begin
         din_s1 <= serial_in_pin;
         din_s2 <= din_s1;
         din_s3 <= din_s2;
         clk_s1 <= serial_clock_pin;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
      end
   end

   // edges seen by sampling; pin rate must stay at or below half aclk
   logic clk_rise, clk_fall, dat_rise, dat_fall;
   assign clk_rise = clk_s2 & ~clk_s3;
   assign clk_fall = ~clk_s2 & clk_s3;
   assign dat_rise = din_s2 & ~din_s3;
   assign dat_fall = ~din_s2 & din_s3;

   // ==========================================================
   // clock source selection
   logic [1:0] wm, cs;
   logic sw_clk, sw_tog, sel_eff, new_port, clk_lvl;
   logic cnt_tick, shift_tick;
   assign wm       = control_reg[usu_pkg::CTL_WM_HI:usu_pkg::CTL_WM_LO];
   assign sw_clk   = ctl_wr & wb[usu_pkg::CTL_SOFT_CLK];
   assign sw_tog   = ctl_wr & wb[usu_pkg::CTL_TOGGLE];
   assign cs       = ctl_wr ? wb[usu_pkg::CTL_CS_HI:usu_pkg::CTL_CS_LO] :
                     control_reg[usu_pkg::CTL_CS_HI:usu_pkg::CTL_CS_LO];
   assign sel_eff  = ctl_wr ? wb[usu_pkg::CTL_SOFT_CLK] : soft_sel_reg;
   assign new_port = ~pin_ctl_reg[usu_pkg::PIN_CLK_PORT];
   assign clk_lvl  = sel_eff ? pin_ctl_reg[usu_pkg::PIN_CLK_PORT] : clk_s2;

   always_comb begin
      cnt_tick   = 1'b0;
      shift_tick = 1'b0;
      if (cs[1] && sel_eff) begin
         cnt_tick   = sw_tog;
         shift_tick = sw_tog & (new_port ^ cs[0]);
      end else if (cs[1]) begin
         cnt_tick   = clk_rise | clk_fall;
         shift_tick = cs[0] ? clk_fall : clk_rise;
      end else if (cs[0]) begin
         cnt_tick   = timer_match;
         shift_tick = timer_match;
      end else begin
         cnt_tick   = sw_clk;
         shift_tick = sw_clk;
      end
   end

   // ==========================================================
   // control register and strobes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_reg  <= usu_pkg::CONTROL_RESET;
         soft_sel_reg <= 1'b0;
      end else if (ce && ctl_wr) begin
         control_reg  <= {wb[7:2], 2'b00};
         soft_sel_reg <= wb[usu_pkg::CTL_SOFT_CLK];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_ctl_reg <= usu_pkg::PIN_RESET;
      end else if (ce) begin
         if (pin_wr) begin
            pin_ctl_reg <= wb[3:0];
         end
         if (sw_tog) begin
            pin_ctl_reg[usu_pkg::PIN_CLK_PORT] <= new_port;
         end
      end
   end

   // ==========================================================
   // shift register, counter and receive copy
   logic [7:0] shift_next;
   logic       ovf_evt;
   assign shift_next = shift_tick ? {shift_data_reg[6:0], din_s2} : shift_data_reg;
   assign ovf_evt    = cnt_tick & ~st_wr & (clock_count == usu_pkg::COUNT_MAX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_data_reg <= usu_pkg::SHIFT_RESET;
      end else if (ce) begin
         if (sd_wr) begin
            shift_data_reg <= wb;
         end else begin
            shift_data_reg <= shift_next;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_count <= 4'h0;
      end else if (ce) begin
         if (st_wr) begin
            clock_count <= wb[3:0];
         end else if (cnt_tick) begin
            clock_count <= clock_count + 4'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_copy_reg <= usu_pkg::SHIFT_RESET;
      end else if (ce && ovf_evt) begin
         receive_copy_reg <= sd_wr ? wb : shift_next;
      end
   end

   // ==========================================================
   // flags, set wins over write-one clear
   logic start_evt, stop_evt;
   assign start_evt = wm[1] ? (dat_fall & clk_s2) : (clk_rise | clk_fall);
   assign stop_evt  = wm[1] & dat_rise & clk_s2;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_flag    <= 1'b0;
         overflow_flag <= 1'b0;
         stop_flag     <= 1'b0;
      end else if (ce) begin
         if (start_evt) begin
            start_flag <= 1'b1;
         end else if (st_wr && wb[usu_pkg::ST_START]) begin
            start_flag <= 1'b0;
         end
         if (ovf_evt) begin
            overflow_flag <= 1'b1;
         end else if (st_wr && wb[usu_pkg::ST_OVF]) begin
            overflow_flag <= 1'b0;
         end
         if (stop_evt) begin
            stop_flag <= 1'b1;
         end else if (st_wr && wb[usu_pkg::ST_STOP]) begin
            stop_flag <= 1'b0;
         end
      end
   end

   // start detector holds clock after master's falling edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_hold_reg <= 1'b0;
      end else if (ce) begin
         if (!wm[1] || (st_wr && wb[usu_pkg::ST_START] && !start_evt)) begin
            start_hold_reg <= 1'b0;
         end else if (start_flag && clk_fall) begin
            start_hold_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // output latch and pins
   logic transparent, latch_val, coll, clk_hold;
   assign transparent = ~cs[1] | (cs[0] ? clk_lvl : ~clk_lvl);
   assign latch_val   = transparent ? shift_data_reg[7] : latch_reg;
   assign coll        = shift_data_reg[7] ^ din_s2;
   assign clk_hold    = start_hold_reg | ((wm == usu_pkg::WM_TWO_HOLD) & overflow_flag);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_reg <= 1'b1;
      end else if (ce) begin
         latch_reg <= latch_val;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_pin_out  <= 1'b0;
         data_pin_oe   <= 1'b0;
         clock_pin_out <= 1'b0;
         clock_pin_oe  <= 1'b0;
      end else if (ce) begin
         if (wm[1]) begin
            data_pin_out  <= 1'b0;
            data_pin_oe   <= pin_ctl_reg[usu_pkg::PIN_DATA_DIR] &
                             (~latch_val | ~pin_ctl_reg[usu_pkg::PIN_DAT_PORT]);
            clock_pin_out <= 1'b0;
            clock_pin_oe  <= pin_ctl_reg[usu_pkg::PIN_CLK_DIR] &
                             (~pin_ctl_reg[usu_pkg::PIN_CLK_PORT] | clk_hold);
         end else begin
            data_pin_out  <= wm[0] ? latch_val : pin_ctl_reg[usu_pkg::PIN_DAT_PORT];
            data_pin_oe   <= pin_ctl_reg[usu_pkg::PIN_DATA_DIR];
            clock_pin_out <= pin_ctl_reg[usu_pkg::PIN_CLK_PORT];
            clock_pin_oe  <= pin_ctl_reg[usu_pkg::PIN_CLK_DIR];
         end
      end
   end

   // ==========================================================
   // interrupt requests
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_irq    <= 1'b0;
         overflow_irq <= 1'b0;
         start_wake   <= 1'b0;
      end else if (ce) begin
         start_irq    <= start_flag & control_reg[usu_pkg::CTL_START_IE] & global_irq_enable;
         overflow_irq <= overflow_flag & control_reg[usu_pkg::CTL_OVF_IE] & global_irq_enable;
         start_wake   <= start_flag & control_reg[usu_pkg::CTL_START_IE];
      end
   end

   // ==========================================================
   // axi4-lite read channel
   logic [7:0] rd_byte;
   logic       rd_ok;
   always_comb begin
      rd_byte = 8'h00;
      rd_ok   = 1'b1;
      if (hit(araddr, usu_pkg::IDX_CONTROL)) begin
         rd_byte = control_reg;
      end else if (hit(araddr, usu_pkg::IDX_STATUS)) begin
         rd_byte = {start_flag, overflow_flag, stop_flag, coll, clock_count};
      end else if (hit(araddr, usu_pkg::IDX_SHIFT)) begin
         rd_byte = shift_data_reg;
      end else if (hit(araddr, usu_pkg::IDX_RECEIVE)) begin
         rd_byte = receive_copy_reg;
      end else if (hit(araddr, usu_pkg::IDX_PIN_CTL)) begin
         rd_byte = {4'h0, pin_ctl_reg};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= usu_pkg::RESP_OKAY;
      end else if (ce) begin
         if (ar_hs) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_byte};
            rresp   <= rd_ok ? usu_pkg::RESP_OKAY : usu_pkg::RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // assertions
   property p_write_wins;
      @(posedge aclk) disable iff (!aresetn)
      ce && sd_wr |=> shift_data_reg == $past(wb_reg);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("data write lost");

   property p_ext_both_edges;
      @(posedge aclk) disable iff (!aresetn)
      ce && cs[1] && !sel_eff && (clk_rise || clk_fall) && !st_wr
      |=> clock_count == $past(clock_count) + 4'h1;
   endproperty
   a_ext_both_edges: assert property (p_ext_both_edges) else $error("edge not counted");

   property p_ovf_copy;
      @(posedge aclk) disable iff (!aresetn)
      ce && ovf_evt && !sd_wr
      |=> overflow_flag && receive_copy_reg == $past(shift_next) && clock_count == 4'h0;
   endproperty
   a_ovf_copy: assert property (p_ovf_copy) else $error("overflow copy wrong");

   property p_start_sticky;
      @(posedge aclk) disable iff (!aresetn)
      start_flag && !(ce && st_wr && wb_reg[usu_pkg::ST_START]) |=> start_flag;
   endproperty
   a_start_sticky: assert property (p_start_sticky) else $error("start flag dropped");

   property p_hold_ovf;
      @(posedge aclk) disable iff (!aresetn)
      ce && wm == usu_pkg::WM_TWO_HOLD && overflow_flag
      && pin_ctl_reg[usu_pkg::PIN_CLK_DIR] |=> clock_pin_oe && !clock_pin_out;
   endproperty
   a_hold_ovf: assert property (p_hold_ovf) else $error("clock not held");

   property p_dir_gate;
      @(posedge aclk) disable iff (!aresetn)
      ce && !pin_ctl_reg[usu_pkg::PIN_DATA_DIR] |=> !data_pin_oe;
   endproperty
   a_dir_gate: assert property (p_dir_gate) else $error("data pin driven");

   property p_stop_set;
      @(posedge aclk) disable iff (!aresetn)
      ce && stop_evt |=> stop_flag ##1 (stop_flag || $past(st_wr));
   endproperty
   a_stop_set: assert property (p_stop_set) else $error("stop flag missed");

   property p_start_irq;
      @(posedge aclk) disable iff (!aresetn)
      ce && start_flag && control_reg[usu_pkg::CTL_START_IE] && global_irq_enable
      |=> start_irq;
   endproperty
   a_start_irq: assert property (p_start_irq) else $error("start irq missing");

   property p_strobe_zero;
      @(posedge aclk) disable iff (!aresetn)
      ce && ar_hs && hit(araddr, usu_pkg::IDX_CONTROL) |=> rdata[1:0] == 2'b00;
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) else $error("strobe reads one");

   c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) ce && ovf_evt);
   c_start:    cover property (@(posedge aclk) disable iff (!aresetn) ce && wm[1] && start_evt);
   c_collide:  cover property (@(posedge aclk) disable iff (!aresetn) wm[1] && coll);
endmodule // usu_shift_unit
`default_nettype wire

// ==== usu_pkg.sv ====
// constants for the universal serial shift unit
package usu_pkg;
   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [5:0] IDX_CONTROL  = 6'h0d;
   localparam logic [5:0] IDX_STATUS   = 6'h0e;
   localparam logic [5:0] IDX_SHIFT    = 6'h0f;
   localparam logic [5:0] IDX_RECEIVE  = 6'h10;
   localparam logic [5:0] IDX_PIN_CTL  = 6'h11;
   // ==========================================================
   // control register fields
   localparam int CTL_START_IE = 7;
   localparam int CTL_OVF_IE   = 6;
   localparam int CTL_WM_HI    = 5;
   localparam int CTL_WM_LO    = 4;
   localparam int CTL_CS_HI    = 3;
   localparam int CTL_CS_LO    = 2;
   localparam int CTL_SOFT_CLK = 1;
   localparam int CTL_TOGGLE   = 0;
   // ==========================================================
   // status register fields
   localparam int ST_START     = 7;
   localparam int ST_OVF       = 6;
   localparam int ST_STOP      = 5;
   localparam int ST_COLL      = 4;
   // ==========================================================
   // pin control register fields
   localparam int PIN_DATA_DIR = 0;
   localparam int PIN_CLK_DIR  = 1;
   localparam int PIN_CLK_PORT = 2;
   localparam int PIN_DAT_PORT = 3;
   // ==========================================================
   // reset values and codes
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET  = 8'h00;
   localparam logic [7:0] SHIFT_RESET   = 8'h00;
   localparam logic [3:0] PIN_RESET     = 4'h0;
   localparam logic [3:0] COUNT_MAX     = 4'hf;
   localparam logic [1:0] WM_TWO_HOLD   = 2'b11;
   localparam logic [1:0] RESP_OKAY     = 2'b00;
   localparam logic [1:0] RESP_SLVERR   = 2'b10;
endpackage

// ==== usu_far_end.sv ====
// remote serial master driving the clock and data pins
`timescale 1ns/100ps
`default_nettype none
module usu_far_end (
   output logic sck,
   output logic sdi
);
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
   end
   // ==========================================================
   // byte frame, data set while clock low, 160 ns per bit
   task automatic send(input logic [7:0] b);
      #3;  // keep pin changes off the aclk rising edge
      for (int i = 7; i >= 0; i--) begin
         sdi = b[i];
         #80 sck = 1'b1;
         #80 sck = 1'b0;
      end
      sdi = ~sdi;
   endtask
   // ==========================================================
   // single line step for start, stop and edges
   task automatic lines(input logic c, input logic d);
      #83 sck = c;
      sdi = d;
   endtask
endmodule // usu_far_end
`default_nettype wire

// ==== usu_shift_unit_bench.sv ====
// self-checking bench for the universal serial shift unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module usu_shift_unit_bench;
   localparam logic [7:0] A_CTL = {usu_pkg::IDX_CONTROL, 2'b00};
   localparam logic [7:0] A_ST  = {usu_pkg::IDX_STATUS, 2'b00};
   localparam logic [7:0] A_SHD = {usu_pkg::IDX_SHIFT, 2'b00};
   localparam logic [7:0] A_RCV = {usu_pkg::IDX_RECEIVE, 2'b00};
   localparam logic [7:0] A_PIN = {usu_pkg::IDX_PIN_CTL, 2'b00};
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, timer_match, global_irq_enable;
   logic        serial_in_pin, serial_clock_pin, data_pin_out, data_pin_oe, two;
   logic        clock_pin_out, clock_pin_oe, start_irq, overflow_irq, start_wake;
   logic        far_sck, far_sdi, ce;
   logic [7:0]  awaddr, araddr, rv;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, bs, rs;
   int          n_fail, compares, cyc;
   usu_shift_unit dut (
      .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .serial_in_pin, .serial_clock_pin, .timer_match,
      .global_irq_enable, .data_pin_out, .data_pin_oe, .clock_pin_out, .clock_pin_oe,
      .start_irq, .overflow_irq, .start_wake
   );
   usu_far_end far (.sck(far_sck), .sdi(far_sdi));
   // open-drain lines: a driven low wins over the far end
   assign serial_clock_pin = (clock_pin_oe && !clock_pin_out) ? 1'b0 : far_sck;
   assign serial_in_pin = (two && data_pin_oe && !data_pin_out) ? 1'b0 : far_sdi;
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   // ==========================================================
   // bus cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            bs = bresp;
         end
      end while (awvalid || wvalid || bready);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            rv = rdata[7:0];
            rs = rresp;
         end
      end while (arvalid || rready);
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd(A_CTL);
      `CHK(rv, usu_pkg::CONTROL_RESET)
      rd(A_ST);
      `CHK(rv, usu_pkg::STATUS_RESET)
      rd(8'h00);
      `CHK(rs, usu_pkg::RESP_SLVERR)
      wr(8'h00, 8'hff);
      `CHK(bs, usu_pkg::RESP_SLVERR)
   endtask
   task automatic t_soft();
      far.lines(1'b0, 1'b1);
      wr(A_SHD, 8'h81);
      wr(A_CTL, 8'h02);
      rd(A_SHD);
      `CHK(rv, 8'h03)
      rd(A_CTL);
      `CHK(rv, 8'h00)
      wr(A_CTL, 8'h04);
      timer_match <= 1'b1;
      w(1);
      timer_match <= 1'b0;
      w(2);
      rd(A_ST);
      `CHK(rv[3:0], 4'h2)
      rd(A_SHD);
      `CHK(rv, 8'h07)
      ce <= 1'b0;
      timer_match <= 1'b1;
      w(1);
      ce <= 1'b1;
      timer_match <= 1'b0;
      rd(A_ST);
      `CHK(rv[3:0], 4'h2)
      wr(A_CTL, 8'h0b);
      rd(A_ST);
      `CHK(rv[3:0], 4'h3)
      rd(A_PIN);
      `CHK(rv[2], 1'b1)
      `CHK(clock_pin_out, 1'b1)
   endtask
   task automatic t_ext();
      wr(A_PIN, 8'h00);
      wr(A_CTL, 8'h58);
      wr(A_ST, 8'hf0);
      far.send(8'ha5);
      w(8);
      rd(A_ST);
      `CHK(rv & 8'hef, 8'hc0)
      `CHK(overflow_irq, 1'b0)
      global_irq_enable <= 1'b1;
      w(3);
      `CHK(overflow_irq, 1'b1)
      rd(A_SHD);
      `CHK(rv, 8'ha5)
      rd(A_RCV);
      `CHK(rv, 8'ha5)
      wr(A_ST, 8'h40);
      w(3);
      `CHK(overflow_irq, 1'b0)
   endtask
   task automatic t_edge();
      wr(A_CTL, 8'h48);
      wr(A_ST, 8'hcf);
      far.lines(1'b1, 1'b0);
      w(6);
      rd(A_ST);
      `CHK(rv[6], 1'b1)
      `CHK(rv[3:0], 4'h0)
   endtask
   task automatic t_out();
      wr(A_CTL, 8'h10);
      wr(A_PIN, 8'h01);
      wr(A_SHD, 8'h80);
      w(1);
      `CHK(data_pin_out, 1'b1)
      `CHK(data_pin_oe, 1'b1)
      wr(A_SHD, 8'h00);
      w(1);
      `CHK(data_pin_out, 1'b0)
      wr(A_PIN, 8'h00);
      w(1);
      `CHK(data_pin_oe, 1'b0)
   endtask
   task automatic t_two();
      two = 1'b1;
      far.lines(1'b1, 1'b1);
      wr(A_PIN, 8'h06);
      wr(A_CTL, 8'ha0);
      wr(A_ST, 8'he0);
      far.lines(1'b1, 1'b0);
      far.lines(1'b0, 1'b0);
      w(6);
      rd(A_ST);
      `CHK(rv[7], 1'b1)
      `CHK(clock_pin_oe, 1'b1)
      `CHK(start_irq, 1'b1)
      `CHK(start_wake, 1'b1)
      wr(A_ST, 8'h80);
      w(3);
      `CHK(clock_pin_oe, 1'b0)
      far.lines(1'b1, 1'b0);
      far.lines(1'b1, 1'b1);
      w(6);
      rd(A_ST);
      `CHK(rv[7:5], 3'b001)
      `CHK(start_irq, 1'b0)
      `CHK(rv[4], 1'b1)
      wr(A_CTL, 8'hb0);
      wr(A_ST, 8'h2f);
      wr(A_CTL, 8'hb2);
      w(2);
      `CHK(clock_pin_oe, 1'b1)
      wr(A_ST, 8'h40);
      w(2);
      `CHK(clock_pin_oe, 1'b0)
   endtask
   task automatic close_out();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      cyc = 0;
      n_fail = 0;
      compares = 0;
      two = 1'b0;
      ce = 1'b1;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, timer_match} = 6'h00;
      global_irq_enable = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'hf;
      w(2);
      aresetn <= 1'b1;
      t_reset();
      t_soft();
      t_ext();
      t_edge();
      t_out();
      t_two();
      close_out();
   end
endmodule // usu_shift_unit_bench
`default_nettype wire
